// file: ilf_pkg.sv
package ilf_pkg;
  // register byte addresses
  localparam logic [31:0] ILF_OFF_FILT_SLOW_DIS = 32'h400e_0e80;
  localparam logic [31:0] ILF_OFF_FILT_SLOW_EN = 32'h400e_0e84;
  localparam logic [31:0] ILF_OFF_FILTER_SELECT_STATUS = 32'h400e_0e88;
  localparam logic [31:0] ILF_OFF_DEBOUNCE_DIVIDER = 32'h400e_0e8c;
  localparam logic [31:0] ILF_OFF_PULLDOWN_DISABLE = 32'h400e_0e90;
  localparam logic [31:0] ILF_OFF_PULLDOWN_ENABLE = 32'h400e_0e94;
  localparam logic [31:0] ILF_OFF_PULLDOWN_STATUS = 32'h400e_0e98;
  localparam logic [31:0] ILF_OFF_OUTPUT_WRITE_ENABLE = 32'h400e_0ea0;
  localparam logic [31:0] ILF_OFF_OUTPUT_WRITE_DISABLE = 32'h400e_0ea4;
  localparam logic [31:0] ILF_OFF_OUTPUT_WRITE_STATUS = 32'h400e_0ea8;
  localparam logic [31:0] ILF_OFF_EXTRA_IRQ_MODE_ENABLE = 32'h400e_0eb0;
  localparam logic [31:0] ILF_OFF_EXTRA_IRQ_MODE_DISABLE = 32'h400e_0eb4;
  localparam logic [31:0] ILF_OFF_EXTRA_IRQ_MODE_STATUS = 32'h400e_0eb8;
  localparam logic [31:0] ILF_OFF_EDGE_SELECT = 32'h400e_0ec0;
  localparam logic [31:0] ILF_OFF_LEVEL_SELECT = 32'h400e_0ec4;
  localparam logic [31:0] ILF_OFF_EDGE_LEVEL_STATUS = 32'h400e_0ec8;
  localparam logic [31:0] ILF_OFF_FALL_SELECT = 32'h400e_0ed0;
  localparam logic [31:0] ILF_OFF_RISE_SELECT = 32'h400e_0ed4;
  localparam logic [31:0] ILF_OFF_FALL_RISE_STATUS = 32'h400e_0ed8;
  localparam logic [31:0] ILF_OFF_WRITE_PROTECT = 32'h400e_0ee4;
  localparam logic [31:0] ILF_OFF_OUTPUT_DATA_REGISTER = 32'h400e_0f20;
  localparam logic [31:0] ILF_OFF_IRQ_STATUS = 32'h400e_0f30;
  localparam logic [31:0] ILF_OFF_IRQ_CLEAR = 32'h400e_0f34;
  localparam logic [31:0] ILF_OFF_IRQ_ENABLE = 32'h400e_0f38;
  // field layout
  localparam int ILF_DIV_W = 14;
  localparam int ILF_WP_KEY_LSB = 8;
  localparam logic [23:0] ILF_WP_KEY = 24'h5049_4f;
  localparam int ILF_WP_ON_BIT = 0;
  // reset values
  localparam logic [31:0] ILF_RST_WORD = 32'h0000_0000;
  localparam logic [13:0] ILF_RST_DIV = 14'h0000;
  // bus answers
  localparam logic [1:0] ILF_RESP_OKAY = 2'h0;
  localparam logic [1:0] ILF_RESP_SLVERR = 2'h2;
  // timing: slow clock period against the 8 ns bus clock
  localparam int ILF_CLK_PERIOD_NS = 8;
  localparam int ILF_SLCK_PERIOD_NS = 30518;
  localparam int ILF_SLCK_CYCLES = ILF_SLCK_PERIOD_NS / ILF_CLK_PERIOD_NS;
  localparam int ILF_SLCK_W = 16;
  // write channel state, one-hot
  typedef enum logic [1:0] {
    ILF_IDLE = 2'b01,
    ILF_BUSY = 2'b10
  } ilf_bus_e;
endpackage

// file: ilf_top.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
// Operation
// [RULE_01] A line on slow-clock filtering drops pulses shorter than half the divided slow period.
// [RULE_02] Filter status reads 0 for the peripheral-clock glitch filter and 1 for debouncing.
// [RULE_03] The debounce period is (divider+1)*2 slow periods, divider in bits 13..0.
// [RULE_04] A 1 written to pull-down disable turns that line's pull-down off, a 0 does nothing.
// [RULE_05] A 1 written to pull-down enable turns that line's pull-down on, a 0 does nothing.
// [RULE_06] Pull-down status reads 0 when the pull-down is on and 1 when it is off.
// [RULE_07] Pull-down and output-write enable/disable writes are ignored while protection is on.
// [RULE_08] A 1 written to output-write enable lets output data writes reach that line.
// [RULE_09] A 1 written to output-write disable makes output data writes skip that line.
// [RULE_10] Output-write status reads 1 for lines that follow output data writes, else 0.
// [RULE_11] A 1 written to extra mode enable makes the line use its edge/level and polarity picks.
// [RULE_12] A 1 written to extra mode disable returns the line to both-edge detection.
// [RULE_13] Extra mode status reads 0 for both-edge lines and 1 for lines in the extra modes.
// [RULE_14] A 1 written to edge select makes the line's extra-mode source an edge event.
// [RULE_15] Every line bit is handled alone and status follows its latest accepted write.
module ilf_top
  import ilf_pkg::*;
#(
  parameter int SLCK_CYC = ILF_SLCK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] line_in,
  output logic [31:0] line_level,
  output logic [31:0] pulldown_on,
  output logic [31:0] out_data,
  output logic irq
);

  typedef struct packed {
    ilf_bus_e wst;
    logic awready;
    logic wready;
    logic arready;
    logic have_aw;
    logic [31:0] aw_addr;
    logic have_w;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] filt_sel;
    logic [13:0] div;
    logic [31:0] pd_on;
    logic [31:0] ow_en;
    logic [31:0] aim;
    logic [31:0] elsel;
    logic [31:0] frlh;
    logic wp_on;
    logic [31:0] odata;
    logic [31:0] irq_stat;
    logic [31:0] irq_en;
    logic irq;
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [31:0] glitch_prev;
    logic [31:0] glitch_out;
    logic [ILF_SLCK_W-1:0] slck_cnt;
    logic [13:0] div_cnt;
    logic [31:0] deb_prev;
    logic [31:0] deb_out;
    logic [31:0] filt;
    logic [31:0] filt_prev;
  } ilf_state_s;

  ilf_state_s q;
  ilf_state_s next_q;

  // byte strobes widened to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[8*i +: 8] = {8{s[i]}};
    end
    return m;
  endfunction

  // take new bits where mask is set, keep old elsewhere
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                        input logic [31:0] mask);
    return (old & ~mask) | (nv & mask);
  endfunction

  logic wr_go;
  logic [31:0] wr_m;
  logic [31:0] wr_bits;
  logic slck_tick;
  logic samp_tick;
  logic [31:0] rise;
  logic [31:0] fall;
  logic [31:0] ev;

  // a write commits once address and data are both held and no answer is pending
  assign wr_go = q.have_aw & q.have_w & (q.wst == ILF_IDLE);
  assign wr_m = strb_mask(q.w_strb);
  assign wr_bits = q.w_data & wr_m;

  // slow clock as an enable; the divided tick comes every divider+1 slow ticks,
  // which is half the debounce period, so a pulse must span two samples
  assign slck_tick = (q.slck_cnt == ILF_SLCK_W'(SLCK_CYC - 1));
  assign samp_tick = slck_tick & (q.div_cnt == q.div);

  // edges of the filtered line
  assign rise = q.filt & ~q.filt_prev;
  assign fall = ~q.filt & q.filt_prev;

  // per-line interrupt source: both edges by default, else edge/level with polarity
  // [RULE_11] extra mode select
  assign ev = (~q.aim & (rise | fall)) |
              (q.aim & ~q.elsel & ((q.frlh & rise) | (~q.frlh & fall))) |
              (q.aim & q.elsel & ((q.frlh & q.filt) | (~q.frlh & ~q.filt)));

  // whole next-state computation
  always_comb begin
    next_q = q;
    // input synchroniser, first stage feeds only the second
    next_q.sync1 = line_in;
    next_q.sync2 = q.sync1;
    // glitch filter: a level must hold two clocks, which kills sub-cycle spikes
    next_q.glitch_prev = q.sync2;
    next_q.glitch_out = merge(q.glitch_out, q.sync2, ~(q.sync2 ^ q.glitch_prev));
    // [RULE_03] divided slow clock
    next_q.slck_cnt = slck_tick ? '0 : q.slck_cnt + 1'b1;
    if (slck_tick) begin
      next_q.div_cnt = (q.div_cnt >= q.div) ? 14'h0000 : q.div_cnt + 1'b1;
    end
    // [RULE_01] debounce needs two equal samples
    if (samp_tick) begin
      next_q.deb_prev = q.sync2;
      next_q.deb_out = merge(q.deb_out, q.sync2, ~(q.sync2 ^ q.deb_prev));
    end
    // [RULE_02] per-line filter choice
    next_q.filt = (q.filt_sel & q.deb_out) | (~q.filt_sel & q.glitch_out);
    next_q.filt_prev = q.filt;

    // write answer retires on bready
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
      next_q.wst = ILF_IDLE;
    end
    if (s_axi_awvalid && q.awready) begin
      next_q.have_aw = 1'b1;
      next_q.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      next_q.have_w = 1'b1;
      next_q.w_data = s_axi_wdata;
      next_q.w_strb = s_axi_wstrb;
    end
    // [RULE_15] set/clear writes touch only the lines with a 1; divider and irq enable writes take all strobed bits, output data only strobed bits with ow_en set
    if (wr_go) begin
      next_q.wst = ILF_BUSY;
      next_q.bvalid = 1'b1;
      next_q.bresp = ILF_RESP_OKAY;
      next_q.have_aw = 1'b0;
      next_q.have_w = 1'b0;
      case (q.aw_addr)
        ILF_OFF_FILT_SLOW_DIS: begin
          next_q.filt_sel = q.filt_sel & ~wr_bits;
        end
        ILF_OFF_FILT_SLOW_EN: begin
          next_q.filt_sel = q.filt_sel | wr_bits;
        end
        ILF_OFF_DEBOUNCE_DIVIDER: begin
          next_q.div = ILF_DIV_W'(merge({18'h0_0000, q.div}, q.w_data, wr_m));
        end
        // [RULE_04] [RULE_07] protected pull-down off
        ILF_OFF_PULLDOWN_DISABLE: begin
          if (!q.wp_on) begin
            next_q.pd_on = q.pd_on & ~wr_bits;
          end
        end
        // [RULE_05] [RULE_07] protected pull-down on
        ILF_OFF_PULLDOWN_ENABLE: begin
          if (!q.wp_on) begin
            next_q.pd_on = q.pd_on | wr_bits;
          end
        end
        // [RULE_08] [RULE_07] protected write mask open
        ILF_OFF_OUTPUT_WRITE_ENABLE: begin
          if (!q.wp_on) begin
            next_q.ow_en = q.ow_en | wr_bits;
          end
        end
        // [RULE_09] [RULE_07] protected write mask shut
        ILF_OFF_OUTPUT_WRITE_DISABLE: begin
          if (!q.wp_on) begin
            next_q.ow_en = q.ow_en & ~wr_bits;
          end
        end
        // [RULE_08] [RULE_09] output data honours the write mask
        ILF_OFF_OUTPUT_DATA_REGISTER: begin
          next_q.odata = merge(q.odata, q.w_data, wr_m & q.ow_en);
        end
        // [RULE_11] extra modes on
        ILF_OFF_EXTRA_IRQ_MODE_ENABLE: begin
          next_q.aim = q.aim | wr_bits;
        end
        // [RULE_12] back to both edges
        ILF_OFF_EXTRA_IRQ_MODE_DISABLE: begin
          next_q.aim = q.aim & ~wr_bits;
        end
        // [RULE_14] edge source
        ILF_OFF_EDGE_SELECT: begin
          next_q.elsel = q.elsel & ~wr_bits;
        end
        ILF_OFF_LEVEL_SELECT: begin
          next_q.elsel = q.elsel | wr_bits;
        end
        ILF_OFF_FALL_SELECT: begin
          next_q.frlh = q.frlh & ~wr_bits;
        end
        ILF_OFF_RISE_SELECT: begin
          next_q.frlh = q.frlh | wr_bits;
        end
        // a wrong key leaves the protection bit alone
        ILF_OFF_WRITE_PROTECT: begin
          if (q.w_data[31:ILF_WP_KEY_LSB] == ILF_WP_KEY && (&q.w_strb)) begin
            next_q.wp_on = q.w_data[ILF_WP_ON_BIT];
          end
        end
        ILF_OFF_IRQ_CLEAR: begin
          next_q.irq_stat = q.irq_stat & ~wr_bits;
        end
        ILF_OFF_IRQ_ENABLE: begin
          next_q.irq_en = merge(q.irq_en, q.w_data, wr_m);
        end
        default: begin
          next_q.bresp = ILF_RESP_SLVERR;
        end
      endcase
    end
    // set after clear, so an event in the clearing cycle survives
    next_q.irq_stat = next_q.irq_stat | ev;
    next_q.irq = |(next_q.irq_stat & next_q.irq_en);
    next_q.awready = ~next_q.have_aw;
    next_q.wready = ~next_q.have_w;

    // read channel: data one edge after the address is taken
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      next_q.rvalid = 1'b1;
      next_q.rresp = ILF_RESP_OKAY;
      case (s_axi_araddr)
        // [RULE_02] filter status
        ILF_OFF_FILTER_SELECT_STATUS: next_q.rdata = q.filt_sel;
        ILF_OFF_DEBOUNCE_DIVIDER: next_q.rdata = {18'h0_0000, q.div};
        // [RULE_06] inverted pull-down status
        ILF_OFF_PULLDOWN_STATUS: next_q.rdata = ~q.pd_on;
        // [RULE_10] write mask status
        ILF_OFF_OUTPUT_WRITE_STATUS: next_q.rdata = q.ow_en;
        // [RULE_13] extra mode status
        ILF_OFF_EXTRA_IRQ_MODE_STATUS: next_q.rdata = q.aim;
        ILF_OFF_EDGE_LEVEL_STATUS: next_q.rdata = q.elsel;
        ILF_OFF_FALL_RISE_STATUS: next_q.rdata = q.frlh;
        ILF_OFF_WRITE_PROTECT: next_q.rdata = {31'h0000_0000, q.wp_on};
        ILF_OFF_OUTPUT_DATA_REGISTER: next_q.rdata = q.odata;
        ILF_OFF_IRQ_STATUS: next_q.rdata = q.irq_stat;
        ILF_OFF_IRQ_ENABLE: next_q.rdata = q.irq_en;
        default: begin
          next_q.rdata = ILF_RST_WORD;
          next_q.rresp = ILF_RESP_SLVERR;
        end
      endcase
    end
    next_q.arready = ~next_q.rvalid;
  end

  // state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.wst <= ILF_IDLE;
      q.div <= ILF_RST_DIV;
      q.pd_on <= ILF_RST_WORD;
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign line_level = q.filt;
  assign pulldown_on = q.pd_on;
  assign out_data = q.odata;
  assign irq = q.irq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wr(logic [31:0] a);
    wr_go && q.aw_addr == a;
  endsequence

  sequence s_rd(logic [31:0] a);
    s_axi_arvalid && q.arready && s_axi_araddr == a;
  endsequence

  a_pd_enable_set: assert property ( // [RULE_05]
    s_wr(ILF_OFF_PULLDOWN_ENABLE) ##0 !q.wp_on |=> (q.pd_on & $past(wr_bits)) == $past(wr_bits))
    else $error("pull-down enable write did not set lines");
  a_pd_disable_clr: assert property ( // [RULE_04]
    s_wr(ILF_OFF_PULLDOWN_DISABLE) ##0 !q.wp_on |=> (q.pd_on & $past(wr_bits)) == 32'h0000_0000)
    else $error("pull-down disable write did not clear lines");
  a_wp_blocks_write: assert property ( // [RULE_07]
    (s_wr(ILF_OFF_PULLDOWN_ENABLE) or s_wr(ILF_OFF_OUTPUT_WRITE_DISABLE)) ##0 q.wp_on
    |=> $stable(q.pd_on) && $stable(q.ow_en))
    else $error("protected write changed state");
  a_pd_status_inv: assert property ( // [RULE_06]
    s_rd(ILF_OFF_PULLDOWN_STATUS) |=> s_axi_rvalid && s_axi_rdata == ~$past(q.pd_on))
    else $error("pull-down status not inverted");
  a_ow_status_read: assert property ( // [RULE_10]
    s_rd(ILF_OFF_OUTPUT_WRITE_STATUS) |=> s_axi_rdata == $past(q.ow_en))
    else $error("output write status mismatch");
  a_odata_masked: assert property ( // [RULE_09]
    s_wr(ILF_OFF_OUTPUT_DATA_REGISTER) |=> ((q.odata ^ $past(q.odata)) & ~$past(q.ow_en)) == 0)
    else $error("masked output line changed");
  a_aim_disable: assert property ( // [RULE_12]
    s_wr(ILF_OFF_EXTRA_IRQ_MODE_DISABLE) |=> (q.aim & $past(wr_bits)) == 32'h0000_0000)
    else $error("extra mode disable ignored");
  a_ow_enable_set: assert property ( // [RULE_08]
    s_wr(ILF_OFF_OUTPUT_WRITE_ENABLE) ##0 !q.wp_on |=> (q.ow_en & $past(wr_bits)) == $past(wr_bits))
    else $error("output write enable did not open lines");
  a_edge_sel_clr: assert property ( // [RULE_14]
    s_wr(ILF_OFF_EDGE_SELECT) |=> (q.elsel & $past(wr_bits)) == 32'h0000_0000)
    else $error("edge select left a line in level mode");
  a_both_edge_evt: assert property ( // [RULE_12]
    !q.aim[0] && (q.filt[0] != q.filt_prev[0]) |=> q.irq_stat[0])
    else $error("both-edge event lost");
  a_deb_on_tick: assert property ( // [RULE_01]
    q.deb_out != $past(q.deb_out) |-> $past(samp_tick))
    else $error("debounce changed off the sample tick");
  a_div_cnt_range: assert property ( // [RULE_03]
    slck_tick && q.div_cnt == q.div |=> q.div_cnt == 14'h0000)
    else $error("divider count did not wrap");
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");

endmodule

// file: io_line_filter_pulldown_irq_mode_tb.sv
`timescale 1ns/1ns
module io_line_filter_pulldown_irq_mode_tb;
  import ilf_pkg::*;
  // short slow tick keeps the debounce run brief
  localparam int SLCK = 2;
  localparam logic [1:0] OK = ILF_RESP_OKAY;
  localparam logic [1:0] ERR = ILF_RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0000_0000;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [31:0] s_axi_araddr = 32'h0000_0000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] line_in = 32'h0000_0000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, line_level, pulldown_on, out_data;
  int fails = 0;
  int check_count = 0;

  ilf_top #(.SLCK_CYC(SLCK)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .line_in(line_in), .line_level(line_level),
    .pulldown_on(pulldown_on), .out_data(out_data), .irq(irq)
  );

  // 125 MHz bus clock
  always #4 aclk = ~aclk;

  // one comparison, counted, reported at once on mismatch
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // handshakes are sampled at the falling edge, where nothing changes, so no race
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_hs, w_hs, b_hs, done;
    int n;
    done = 0;
    n = 0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done && n < 100) begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bready && s_axi_bvalid;
      if (b_hs) r = s_axi_bresp;
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      if (b_hs) begin
        s_axi_bready <= 1'b0;
        done = 1;
      end
      n++;
    end
    if (!done) chk(a, 32'hffff_ffff);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
    bit ar_hs, r_hs, done;
    int n;
    done = 0;
    n = 0;
    r = 2'h3;
    v = 32'hdead_beef;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done && n < 100) begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rready && s_axi_rvalid;
      if (r_hs) begin
        v = s_axi_rdata;
        r = s_axi_rresp;
      end
      @(posedge aclk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
      if (r_hs) begin
        s_axi_rready <= 1'b0;
        done = 1;
      end
      n++;
    end
    if (!done) chk(a, 32'hffff_ffff);
  endtask

  task automatic wrc(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic rc(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0] r;
    rd(a, v, r);
    chk(v, e);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    test_done();
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // reset state
    rc(ILF_OFF_PULLDOWN_STATUS, 32'hffff_ffff, OK);
    rc(ILF_OFF_FILTER_SELECT_STATUS, 32'h0000_0000, OK);
    rc(ILF_OFF_OUTPUT_WRITE_STATUS, 32'h0000_0000, OK);
    rc(ILF_OFF_EXTRA_IRQ_MODE_STATUS, 32'h0000_0000, OK);
    $display("reset values done");
    // pull-down set and clear, zeros leave lines alone
    wrc(ILF_OFF_PULLDOWN_ENABLE, 32'h0000_00f0, OK);
    rc(ILF_OFF_PULLDOWN_STATUS, 32'hffff_ff0f, OK);
    wrc(ILF_OFF_PULLDOWN_DISABLE, 32'h0000_0030, OK);
    wrc(ILF_OFF_PULLDOWN_ENABLE, 32'h0000_0000, OK);
    rc(ILF_OFF_PULLDOWN_STATUS, 32'hffff_ff3f, OK);
    chk(pulldown_on, 32'h0000_00c0);
    $display("pull-down done");
    // output write mask gates the output data register
    wrc(ILF_OFF_OUTPUT_WRITE_ENABLE, 32'h0000_ff00, OK);
    rc(ILF_OFF_OUTPUT_WRITE_STATUS, 32'h0000_ff00, OK);
    wrc(ILF_OFF_OUTPUT_DATA_REGISTER, 32'hffff_ffff, OK);
    chk(out_data, 32'h0000_ff00);
    wrc(ILF_OFF_OUTPUT_WRITE_DISABLE, 32'h0000_0f00, OK);
    rc(ILF_OFF_OUTPUT_WRITE_STATUS, 32'h0000_f000, OK);
    wrc(ILF_OFF_OUTPUT_DATA_REGISTER, 32'h0000_0000, OK);
    chk(out_data, 32'h0000_0f00);
    $display("output write mask done");
    // protected writes are answered but dropped
    wrc(ILF_OFF_WRITE_PROTECT, 32'h5049_4f01, OK);
    rc(ILF_OFF_WRITE_PROTECT, 32'h0000_0001, OK);
    wrc(ILF_OFF_PULLDOWN_ENABLE, 32'hffff_ffff, OK);
    wrc(ILF_OFF_OUTPUT_WRITE_ENABLE, 32'hffff_ffff, OK);
    wrc(ILF_OFF_PULLDOWN_DISABLE, 32'hffff_ffff, OK);
    wrc(ILF_OFF_OUTPUT_WRITE_DISABLE, 32'hffff_ffff, OK);
    rc(ILF_OFF_PULLDOWN_STATUS, 32'hffff_ff3f, OK);
    rc(ILF_OFF_OUTPUT_WRITE_STATUS, 32'h0000_f000, OK);
    wrc(ILF_OFF_WRITE_PROTECT, 32'h5049_4f00, OK);
    // unmapped, write-only and read-only places
    rc(32'h400e_0e9c, 32'h0000_0000, ERR);
    rc(ILF_OFF_PULLDOWN_ENABLE, 32'h0000_0000, ERR);
    wrc(ILF_OFF_PULLDOWN_STATUS, 32'h0000_0000, ERR);
    $display("protection and errors done");
    // divider keeps only its low 14 bits
    wrc(ILF_OFF_DEBOUNCE_DIVIDER, 32'hffff_ffff, OK);
    rc(ILF_OFF_DEBOUNCE_DIVIDER, 32'h0000_3fff, OK);
    wrc(ILF_OFF_DEBOUNCE_DIVIDER, 32'h0000_0001, OK);
    wrc(ILF_OFF_FILT_SLOW_EN, 32'h0000_0006, OK);
    wrc(ILF_OFF_FILT_SLOW_DIS, 32'h0000_0004, OK);
    rc(ILF_OFF_FILTER_SELECT_STATUS, 32'h0000_0002, OK);
    // one-cycle pulse is far under half of 4 slow ticks
    line_in[1] <= 1'b1;
    settle(1);
    line_in[1] <= 1'b0;
    settle(30);
    chk(line_level & 32'h0000_0002, 32'h0000_0000);
    line_in[1] <= 1'b1;
    // still low after 3 cycles, under half of the 8-cycle debounce period
    settle(3);
    chk(line_level & 32'h0000_0002, 32'h0000_0000);
    // a held level must come through within two debounce periods
    for (int i = 0; i < 16 && line_level[1] !== 1'b1; i++) @(negedge aclk);
    chk(line_level & 32'h0000_0002, 32'h0000_0002);
    $display("debounce done");
    // default both-edge interrupt, masked and cleared
    wrc(ILF_OFF_IRQ_CLEAR, 32'hffff_ffff, OK);
    wrc(ILF_OFF_IRQ_ENABLE, 32'h0000_0001, OK);
    line_in[0] <= 1'b1;
    for (int i = 0; i < 30 && irq !== 1'b1; i++) @(negedge aclk);
    chk({31'h0, irq}, 32'h0000_0001);
    rc(ILF_OFF_IRQ_STATUS, 32'h0000_0001, OK);
    wrc(ILF_OFF_IRQ_ENABLE, 32'h0000_0000, OK);
    settle(2);
    chk({31'h0, irq}, 32'h0000_0000);
    wrc(ILF_OFF_IRQ_ENABLE, 32'h0000_0001, OK);
    wrc(ILF_OFF_IRQ_CLEAR, 32'h0000_0001, OK);
    settle(2);
    chk({31'h0, irq}, 32'h0000_0000);
    line_in[0] <= 1'b0;
    for (int i = 0; i < 30 && irq !== 1'b1; i++) @(negedge aclk);
    chk({31'h0, irq}, 32'h0000_0001);
    wrc(ILF_OFF_IRQ_ENABLE, 32'h0000_0000, OK);
    $display("interrupt done");
    // extra modes: line 2 rising edge only
    wrc(ILF_OFF_EXTRA_IRQ_MODE_ENABLE, 32'h0000_0005, OK);
    wrc(ILF_OFF_EXTRA_IRQ_MODE_DISABLE, 32'h0000_0001, OK);
    rc(ILF_OFF_EXTRA_IRQ_MODE_STATUS, 32'h0000_0004, OK);
    wrc(ILF_OFF_LEVEL_SELECT, 32'h0000_0004, OK);
    rc(ILF_OFF_EDGE_LEVEL_STATUS, 32'h0000_0004, OK);
    // low-level mode on a low line raises its status; line 0 still holds its old fall
    rc(ILF_OFF_IRQ_STATUS, 32'h0000_0005, OK);
    wrc(ILF_OFF_EDGE_SELECT, 32'h0000_0004, OK);
    rc(ILF_OFF_EDGE_LEVEL_STATUS, 32'h0000_0000, OK);
    wrc(ILF_OFF_RISE_SELECT, 32'h0000_0004, OK);
    wrc(ILF_OFF_IRQ_CLEAR, 32'hffff_ffff, OK);
    line_in[2] <= 1'b1;
    settle(12);
    rc(ILF_OFF_IRQ_STATUS, 32'h0000_0004, OK);
    wrc(ILF_OFF_IRQ_CLEAR, 32'h0000_0004, OK);
    line_in[2] <= 1'b0;
    settle(12);
    rc(ILF_OFF_IRQ_STATUS, 32'h0000_0000, OK);
    $display("extra modes done");
    test_done();
  end
endmodule
